//--- include/hrs_pkg.sv
package hrs_pkg;

  // Clock rate
  localparam int unsigned CLK_HZ = 10000000;

  // Timing figures in their own units
  localparam int unsigned T_OPER_US = 500;
  localparam int unsigned T_LOAD_US = 99500;
  localparam int unsigned T_ATTACH_MS = 100;
  localparam int unsigned T_REQ_MS = 5;

  // Cycle counts derived from the rate; every time is a whole number of cycles
  localparam int unsigned OPER_CYC = (T_OPER_US * (CLK_HZ / 1000000));
  localparam int unsigned LOAD_CYC = (T_LOAD_US * (CLK_HZ / 1000000));
  localparam int unsigned ATTACH_CYC = (T_ATTACH_MS * (CLK_HZ / 1000));
  localparam int unsigned REQ_CYC = (T_REQ_MS * (CLK_HZ / 1000));

  // Counter width covers the longest count
  localparam int unsigned CNT_W = 24;

  // Configuration space
  localparam int unsigned CFG_AW = 8;
  localparam int unsigned CFG_DW = 8;
  localparam int unsigned CFG_NREG = 17;
  localparam logic [7:0] CFG_RST_VAL = 8'h00;
  localparam logic [7:0] CFG_UNDEF_VAL = 8'h00;

  // Built-in default image applied in strap and default modes
  localparam logic [7:0] CFG_DEFAULT_VAL = 8'h00;

  // Configuration source select encoding
  localparam logic [1:0] SRC_DEFAULT = 2'h0;
  localparam logic [1:0] SRC_STRAP = 2'h1;
  localparam logic [1:0] SRC_EEPROM = 2'h2;
  localparam logic [1:0] SRC_SMBUS = 2'h3;

  // Downstream port count
  localparam int unsigned NPORT = 4;

  // Strap bit positions in the strap register
  localparam int unsigned STRAP_AMBER = 0;
  localparam int unsigned STRAP_GREEN = 1;

  typedef enum logic [2:0] {
    ST_RESET,
    ST_STABILIZE,
    ST_LOAD,
    ST_ATTACH,
    ST_ATTACHED,
    ST_BUS_RESET,
    ST_RUN
  } hrs_state_t;

endpackage

//--- core/hrs_sequencer.sv
`timescale 1ns/1ps
module hrs_sequencer #(
  parameter int unsigned OPER_CYCLES = hrs_pkg::OPER_CYC,
  parameter int unsigned LOAD_CYCLES = hrs_pkg::LOAD_CYC,
  parameter int unsigned ATTACH_CYCLES = hrs_pkg::ATTACH_CYC,
  parameter int unsigned REQ_CYCLES = hrs_pkg::REQ_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [1:0] cfg_src,
  input wire logic smbus_disable,
  input wire logic self_powered,
  input wire logic amber_strap,
  input wire logic green_strap,
  input wire logic load_done,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic bus_reset,
  input wire logic suspend_req,
  input wire logic set_address,
  input wire logic [6:0] new_address,
  input wire logic set_config,
  input wire logic req_start,
  input wire logic req_done,
  input wire logic amber_on,
  input wire logic green_on,
  input wire logic [3:0] port_power_req,
  output logic [7:0] cfg_rdata,
  output logic cfg_ack,
  output logic osc_enable,
  output logic pll_enable,
  output logic phy_enable,
  output logic operational,
  output logic eeprom_fetch,
  output logic load_timeout,
  output logic attach,
  output logic [3:0] downstream_power_enable,
  output logic [3:0] port_enable,
  output logic transaction_translator_flush,
  output logic xact_abort,
  output logic suspended,
  output logic [6:0] dev_address,
  output logic configured,
  output logic req_timeout,
  output logic amber_out,
  output logic amber_oe,
  output logic green_out,
  output logic green_oe
);

  hrs_pkg::hrs_state_t state_q;
  logic [hrs_pkg::CNT_W-1:0] cnt_q;
  logic [hrs_pkg::CNT_W-1:0] req_cnt_q;
  logic req_busy_q;
  logic [1:0] strap_q;
  logic strap_taken_q;
  logic [7:0] cfg_mem_q [hrs_pkg::CFG_NREG];
  logic cfg_hit;
  logic use_straps;

  // Decode of the defined configuration set
  assign cfg_hit = (cfg_addr < 8'(hrs_pkg::CFG_NREG));
  assign use_straps = (cfg_src == hrs_pkg::SRC_DEFAULT) || (cfg_src == hrs_pkg::SRC_STRAP);

  // Start-up and bus reset sequencer
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= hrs_pkg::ST_RESET;
      cnt_q <= '0;
      eeprom_fetch <= 1'b0;
      load_timeout <= 1'b0;
    end else begin
      eeprom_fetch <= 1'b0;
      case (state_q)
        hrs_pkg::ST_RESET: begin
          state_q <= hrs_pkg::ST_STABILIZE;
          cnt_q <= '0;
        end
        hrs_pkg::ST_STABILIZE: begin
          if (cnt_q >= hrs_pkg::CNT_W'(OPER_CYCLES - 1)) begin
            cnt_q <= '0;
            if (cfg_src == hrs_pkg::SRC_EEPROM && !smbus_disable) begin
              eeprom_fetch <= 1'b1;
              state_q <= hrs_pkg::ST_LOAD;
            end else if (cfg_src == hrs_pkg::SRC_SMBUS) begin
              state_q <= hrs_pkg::ST_LOAD;
            end else begin
              state_q <= hrs_pkg::ST_ATTACH;
            end
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        hrs_pkg::ST_LOAD: begin
          if (load_done) begin
            state_q <= hrs_pkg::ST_ATTACH;
            cnt_q <= '0;
          end else if (cnt_q >= hrs_pkg::CNT_W'(LOAD_CYCLES - 1) &&
                       (cfg_src == hrs_pkg::SRC_EEPROM || !self_powered)) begin
            load_timeout <= 1'b1;
            state_q <= hrs_pkg::ST_ATTACH;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        hrs_pkg::ST_ATTACH: begin
          state_q <= hrs_pkg::ST_ATTACHED;
        end
        hrs_pkg::ST_ATTACHED: begin
          if (bus_reset) begin
            state_q <= hrs_pkg::ST_BUS_RESET;
          end
        end
        hrs_pkg::ST_BUS_RESET: begin
          if (!bus_reset) begin
            state_q <= hrs_pkg::ST_RUN;
          end
        end
        hrs_pkg::ST_RUN: begin
          if (bus_reset) begin
            state_q <= hrs_pkg::ST_BUS_RESET;
          end
        end
        default: state_q <= hrs_pkg::ST_RESET;
      endcase
    end
  end

  // Clock and transceiver enables
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_enable <= 1'b0;
      pll_enable <= 1'b0;
      phy_enable <= 1'b0;
      operational <= 1'b0;
      attach <= 1'b0;
    end else begin
      osc_enable <= 1'b1;
      pll_enable <= 1'b1;
      operational <= (state_q != hrs_pkg::ST_RESET) && (state_q != hrs_pkg::ST_STABILIZE);
      phy_enable <= (state_q == hrs_pkg::ST_ATTACH) || (state_q == hrs_pkg::ST_ATTACHED) ||
                    (state_q == hrs_pkg::ST_BUS_RESET) || (state_q == hrs_pkg::ST_RUN);
      attach <= (state_q == hrs_pkg::ST_ATTACH) || (state_q == hrs_pkg::ST_ATTACHED) ||
                (state_q == hrs_pkg::ST_BUS_RESET) || (state_q == hrs_pkg::ST_RUN);
    end
  end

  // Strap capture once after reset release
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_q <= 2'h0;
      strap_taken_q <= 1'b0;
    end else if (!strap_taken_q) begin
      strap_q[hrs_pkg::STRAP_AMBER] <= amber_strap;
      strap_q[hrs_pkg::STRAP_GREEN] <= green_strap;
      strap_taken_q <= 1'b1;
    end
  end

  // Downstream ports; bus reset is not forwarded, power and port enables drop
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      downstream_power_enable <= 4'h0;
      port_enable <= 4'h0;
      transaction_translator_flush <= 1'b0;
    end else begin
      transaction_translator_flush <= bus_reset;
      if (bus_reset || state_q != hrs_pkg::ST_RUN) begin
        downstream_power_enable <= 4'h0;
      end else begin
        downstream_power_enable <= port_power_req;
      end
      port_enable <= (state_q == hrs_pkg::ST_RUN) ? 4'hf : 4'h0;
    end
  end

  // Transaction abort marker held through reset
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      xact_abort <= 1'b1;
    end else begin
      xact_abort <= 1'b0;
    end
  end

  // Device address, configuration and suspend state
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dev_address <= 7'h00;
      configured <= 1'b0;
      suspended <= 1'b0;
    end else if (bus_reset) begin
      dev_address <= 7'h00;
      configured <= 1'b0;
      suspended <= 1'b0;
    end else begin
      if (set_address) begin
        dev_address <= new_address;
      end
      if (set_config) begin
        configured <= 1'b1;
      end
      if (suspend_req) begin
        suspended <= 1'b1;
      end
    end
  end

  // Standard request completion watchdog
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_busy_q <= 1'b0;
      req_cnt_q <= '0;
      req_timeout <= 1'b0;
    end else begin
      req_timeout <= 1'b0;
      if (bus_reset || req_done) begin
        req_busy_q <= 1'b0;
        req_cnt_q <= '0;
      end else if (req_start && state_q == hrs_pkg::ST_RUN) begin
        req_busy_q <= 1'b1;
        req_cnt_q <= '0;
      end else if (req_busy_q) begin
        if (req_cnt_q >= hrs_pkg::CNT_W'(REQ_CYCLES - 1)) begin
          req_timeout <= 1'b1;
          req_busy_q <= 1'b0;
        end else begin
          req_cnt_q <= req_cnt_q + 1'b1;
        end
      end
    end
  end

  // Configuration storage, defaults applied in strap and default modes
  genvar gi;
  generate
    for (gi = 0; gi < hrs_pkg::CFG_NREG; gi++) begin : g_cfg
      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          cfg_mem_q[gi] <= hrs_pkg::CFG_RST_VAL;
        end else if (state_q == hrs_pkg::ST_STABILIZE && use_straps) begin
          cfg_mem_q[gi] <= hrs_pkg::CFG_DEFAULT_VAL;
        end else if (cfg_wr && cfg_hit && cfg_addr == 8'(gi)) begin
          cfg_mem_q[gi] <= cfg_wdata;
        end
      end
    end
  endgenerate

  // Configuration read and write answer
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_rdata <= 8'h00;
      cfg_ack <= 1'b0;
    end else begin
      cfg_ack <= cfg_rd || cfg_wr;
      if (cfg_rd && cfg_hit) begin
        cfg_rdata <= cfg_mem_q[cfg_addr[4:0]];
      end else if (cfg_rd) begin
        cfg_rdata <= hrs_pkg::CFG_UNDEF_VAL;
      end
    end
  end

  // Indicator drive; polarity follows the captured strap in strap and default modes
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      amber_out <= 1'b0;
      amber_oe <= 1'b0;
      green_out <= 1'b0;
      green_oe <= 1'b0;
    end else if (!strap_taken_q || !operational) begin
      amber_out <= 1'b0;
      amber_oe <= 1'b0;
      green_out <= 1'b0;
      green_oe <= 1'b0;
    end else begin
      amber_oe <= 1'b1;
      green_oe <= 1'b1;
      amber_out <= (use_straps && strap_q[hrs_pkg::STRAP_AMBER]) ? !amber_on : amber_on;
      green_out <= (use_straps && strap_q[hrs_pkg::STRAP_GREEN]) ? !green_on : green_on;
    end
  end

endmodule

//--- dv/hrs_seq_assertions.sv
`timescale 1ns/1ps
module hrs_seq_checker #(
  parameter int unsigned OPER_CYCLES = 20
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [1:0] cfg_src,
  input wire logic smbus_disable,
  input wire logic amber_strap,
  input wire logic amber_on,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic bus_reset,
  input wire logic [7:0] cfg_rdata,
  input wire logic cfg_ack,
  input wire logic osc_enable,
  input wire logic pll_enable,
  input wire logic phy_enable,
  input wire logic operational,
  input wire logic eeprom_fetch,
  input wire logic [3:0] downstream_power_enable,
  input wire logic [3:0] port_enable,
  input wire logic transaction_translator_flush,
  input wire logic xact_abort,
  input wire logic suspended,
  input wire logic [6:0] dev_address,
  input wire logic configured,
  input wire logic amber_out
);
  logic first_q;
  logic strap_q;
  logic [15:0] wait_q;
  // Strap copy at first edge after release
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      first_q <= 1'b1;
      strap_q <= 1'b0;
    end else if (first_q) begin
      first_q <= 1'b0;
      strap_q <= amber_strap;
    end
  end
  // Cycles spent before operational
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) wait_q <= 16'h0000;
    else if (!operational) wait_q <= wait_q + 16'h0001;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence release_s;
    $fell(sys_rst);
  endsequence
  oper_bound_a:
    assert property (wait_q <= 16'(OPER_CYCLES + 4)) else $error("late operational");
  reset_quiet_a:
    assert property (release_s |-> !osc_enable && !pll_enable && !phy_enable && xact_abort
      && downstream_power_enable == 4'h0 && port_enable == 4'h0) else $error("live in reset");
  clk_start_a:
    assert property (release_s |=> osc_enable && pll_enable && !xact_abort) else $error("no clock start");
  undef_read_a:
    assert property (cfg_rd && cfg_addr >= 8'h11 |=> cfg_ack && cfg_rdata == 8'h00) else $error("undef read");
  write_ack_a:
    assert property (cfg_wr |=> cfg_ack) else $error("write not acked");
  bus_reset_a:
    assert property (bus_reset |=> downstream_power_enable == 4'h0 && dev_address == 7'h00
      && !configured && !suspended) else $error("bus reset ignored");
  xlat_flush_a:
    assert property (bus_reset |=> transaction_translator_flush) else $error("no flush");
  led_polarity_a:
    assert property (operational && $past(operational, 2) && $stable(amber_on) |->
      amber_out == (amber_on ^ (strap_q & ~cfg_src[1]))) else $error("led polarity");
  fetch_start_a:
    assert property ($rose(operational) && cfg_src == 2'h2 && !smbus_disable |-> $past(eeprom_fetch))
      else $error("no fetch");
  no_fetch_a:
    assert property (smbus_disable |-> !eeprom_fetch) else $error("fetch when disabled");
endmodule
bind hrs_sequencer hrs_seq_checker #(.OPER_CYCLES(OPER_CYCLES)) hrs_seq_checker_i (.*);

//--- dv/hrs_host_model.sv
`timescale 1ns/1ps
module hrs_host_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic eeprom_fetch,
  input wire logic attach,
  input wire logic operational,
  input wire logic kick,
  input wire logic [7:0] lat,
  output logic load_done,
  output logic bus_reset
);
  logic [7:0] ld_q;
  logic [3:0] br_q;
  logic att_q;
  logic op_q;
  // Config host answers a fetch or the start of operation after lat cycles, ff never
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ld_q <= 8'h00;
      op_q <= 1'b0;
      load_done <= 1'b0;
    end else begin
      op_q <= operational;
      if (eeprom_fetch || (operational && !op_q)) ld_q <= lat;
      else if (ld_q != 8'h00 && ld_q != 8'hff) ld_q <= ld_q - 8'h01;
      load_done <= (ld_q == 8'h01);
    end
  end
  // Upstream host signals reset on attach or on demand
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      att_q <= 1'b0;
      br_q <= 4'h0;
      bus_reset <= 1'b0;
    end else begin
      att_q <= attach;
      if ((attach && !att_q) || kick) br_q <= 4'h8;
      else if (br_q != 4'h0) br_q <= br_q - 4'h1;
      bus_reset <= (br_q != 4'h0);
    end
  end
endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int REQ = 30;
  logic core_clk, sys_rst, smbus_disable, self_powered, amber_strap, green_strap, load_done, cfg_wr, cfg_rd;
  logic bus_reset, suspend_req, set_address, set_config, req_start, req_done, amber_on, green_on, kick;
  logic cfg_ack, osc_enable, pll_enable, phy_enable, operational, eeprom_fetch, load_timeout, attach;
  logic transaction_translator_flush, xact_abort, suspended, configured, req_timeout;
  logic amber_out, amber_oe, green_out, green_oe;
  logic [1:0] cfg_src;
  logic [3:0] port_power_req, downstream_power_enable, port_enable;
  logic [6:0] new_address, dev_address;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, lat;
  int errors, samples_checked;
  hrs_sequencer #(.OPER_CYCLES(20), .LOAD_CYCLES(50), .REQ_CYCLES(REQ)) hrs_sequencer_i (.*);
  hrs_host_model hrs_host_model_i (.core_clk(core_clk), .sys_rst(sys_rst), .eeprom_fetch(eeprom_fetch),
    .attach(attach), .operational(operational), .kick(kick), .lat(lat),
    .load_done(load_done), .bus_reset(bus_reset));
  // Clock
  always #50 core_clk = ~core_clk;
  task automatic check(input logic [7:0] s, e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic test_done;
    if (errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic do_reset(input logic [1:0] src, input logic sd, sp, st, input logic [7:0] l);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    {cfg_src, smbus_disable, self_powered, amber_strap, green_strap, lat} <= {src, sd, sp, st, st, l};
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    check(8'({osc_enable, pll_enable, phy_enable, amber_oe, green_oe, xact_abort}), 8'h01);
    check(8'({port_enable, downstream_power_enable}), 8'h00);
    @(posedge core_clk);
    sys_rst <= 1'b0;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, d, e);
    @(posedge core_clk);
    {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} <= {w, !w, a, d};
    @(posedge core_clk);
    {cfg_wr, cfg_rd} <= 2'h0;
    @(negedge core_clk);
    check(8'(cfg_ack), 8'h01);
    if (!w) check(cfg_rdata, e);
  endtask
  task automatic wait_br;
    int n;
    n = 0;
    while (bus_reset !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    while (bus_reset !== 1'b0) @(posedge core_clk);
    repeat (3) @(posedge core_clk);
  endtask
  task automatic t_strap;
    int n;
    do_reset(2'h1, 1'b0, 1'b0, 1'b1, 8'h05);
    n = 0;
    while (operational !== 1'b1 && n < 60) begin
      @(posedge core_clk);
      n++;
    end
    check(8'(n <= 24), 8'h01);
    {amber_strap, green_strap, amber_on, green_on} <= 4'h7;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    check(8'({amber_out, amber_oe, green_out, green_oe}), 8'h05);
    wait_br;
  endtask
  task automatic t_cfg;
    bus(1'b1, 8'h10, 8'ha5, 8'h00);
    bus(1'b0, 8'h10, 8'h00, 8'ha5);
    bus(1'b1, 8'h03, 8'h3c, 8'h00);
    bus(1'b1, 8'h23, 8'hff, 8'h00);
    bus(1'b0, 8'h11, 8'h00, 8'h00);
    bus(1'b0, 8'hff, 8'h00, 8'h00);
    bus(1'b0, 8'h03, 8'h00, 8'h3c);
    bus(1'b1, 8'h10, 8'h00, 8'h00);
    bus(1'b0, 8'h10, 8'h00, 8'h00);
  endtask
  task automatic t_busrst;
    @(posedge core_clk);
    {port_power_req, set_address, new_address, set_config} <= {4'hf, 1'b1, 7'h2a, 1'b1};
    @(posedge core_clk);
    {set_address, set_config} <= 2'h0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    check(8'({downstream_power_enable, configured, dev_address == 7'h2a}), 8'h3f);
    check(8'(port_enable), 8'h0f);
    @(posedge core_clk);
    suspend_req <= 1'b1;
    @(posedge core_clk);
    {suspend_req, kick} <= 2'h1;
    @(posedge core_clk);
    kick <= 1'b0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    check(8'({downstream_power_enable, configured, suspended, transaction_translator_flush}), 8'h01);
    check(8'(dev_address), 8'h00);
    check(8'(port_enable), 8'h00);
    wait_br;
  endtask
  task automatic t_req;
    int n;
    @(posedge core_clk);
    req_start <= 1'b1;
    @(posedge core_clk);
    req_start <= 1'b0;
    repeat (REQ - 10) @(posedge core_clk);
    req_done <= 1'b1;
    @(posedge core_clk);
    {req_done, req_start} <= 2'h1;
    n = 0;
    repeat (REQ + 10) begin
      @(posedge core_clk);
      req_start <= 1'b0;
      if (req_timeout === 1'b1) n++;
    end
    check(8'(n), 8'h01);
  endtask
  task automatic t_mode(input logic [1:0] src, input logic sd, sp, input logic [7:0] l, input logic [2:0] e);
    logic seen;
    seen = 1'b0;
    do_reset(src, sd, sp, 1'b1, l);
    repeat (150) begin
      @(posedge core_clk);
      if (eeprom_fetch === 1'b1) seen = 1'b1;
    end
    @(negedge core_clk);
    check(8'({seen, load_timeout}), 8'(e[2:1]));
    check(8'(attach), 8'(e[0]));
    check(8'({amber_out, green_out}), src[1] ? 8'h03 : 8'h00);
    bus(1'b0, 8'h03, 8'h00, 8'h00);
  endtask
  // Main sequence
  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    {smbus_disable, self_powered, amber_strap, green_strap, cfg_wr, cfg_rd, suspend_req, kick} = '0;
    {set_address, set_config, req_start, req_done, amber_on, green_on, cfg_src, port_power_req} = '0;
    {new_address, cfg_addr, cfg_wdata, lat} = '0;
    t_strap;
    t_cfg;
    t_busrst;
    t_req;
    t_mode(2'h2, 1'b0, 1'b0, 8'h05, 3'h5);
    t_mode(2'h2, 1'b0, 1'b0, 8'hff, 3'h7);
    t_mode(2'h3, 1'b0, 1'b1, 8'hff, 3'h0);
    t_mode(2'h3, 1'b0, 1'b0, 8'h28, 3'h1);
    t_mode(2'h3, 1'b0, 1'b0, 8'hff, 3'h3);
    t_mode(2'h2, 1'b1, 1'b0, 8'h05, 3'h1);
    t_mode(2'h0, 1'b0, 1'b0, 8'h05, 3'h1);
    test_done;
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    test_done;
  end
endmodule
